// file: fkc_pkg.sv
// Shared constants, types and helpers of the front-panel function key controller.
// Assumes a 125 MHz core clock and APB register access with 32-bit data.
//
// Functional notes
// - Ten independent operator keys each drive a command that the scheme logic may use freely.
// - A readable ten-bit status word shows the current command state of every key.
// - The ten key commands leave the block as ten consecutive signals that can go to one.
// - A toggle key flips its command set on one qualified press and clear on the next.
// - A momentary key asserts its command only while held and drops it on release.
// - A per-key enable lets the command act or disables it entirely.
// - A locked toggle key freezes its command and ignores further presses.
// - A locked momentary key keeps its command permanently inactive.
// - Key command states are kept in battery-backed storage and loaded at power return, but reset makes all keys momentary, so they drop a cycle later.
// - With invalid backup storage all key commands start at zero.
// - Only one key press is handled at a time and other keys are ignored meanwhile.
// - A press is accepted only after the key is held for about 200 ms without a break.
// - Each key drives its own programmable three-colour indicator showing its activation.
package fkc_pkg;
    localparam int NUM_KEYS      = 10;
    localparam int IDX_W         = 4;
    localparam int ADDR_W        = 8;
    localparam int QUAL_MS       = 200;
    localparam int CLK_PERIOD_NS = 8;
    localparam int QUAL_CYC      = QUAL_MS * 1000000 / CLK_PERIOD_NS;
    localparam int RESTORE_WAIT  = 3;

    localparam logic [ADDR_W-1:0] ADDR_KEY_STATE = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_BEHAVIOUR = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_ENABLE    = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_LOCK      = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_LED_ON    = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_LED_OFF   = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_STATUS    = 8'h18;

    localparam logic [9:0]  RST_BEHAVIOUR = 10'h000;
    localparam logic [9:0]  RST_ENABLE    = 10'h3ff;
    localparam logic [9:0]  RST_LOCK      = 10'h000;
    localparam logic [19:0] RST_LED_ON    = 20'haaaaa;
    localparam logic [19:0] RST_LED_OFF   = 20'h00000;

    localparam int COL_RED_BIT   = 0;
    localparam int COL_GREEN_BIT = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_HELD_BIT = 1;
    localparam int STAT_IDX_LSB  = 4;
    localparam int STAT_BKP_BIT  = 8;
    localparam int STAT_RUN_BIT  = 9;

    typedef enum logic [2:0] {
        FKC_BOOT_WAIT = 3'b001,
        FKC_BOOT_LOAD = 3'b010,
        FKC_RUN       = 3'b100
    } fkc_boot_t;

    typedef enum logic [2:0] {
        FKC_IDLE = 3'b001,
        FKC_QUAL = 3'b010,
        FKC_HELD = 3'b100
    } fkc_rec_t;

    // Picks one colour plane out of the two-bit-per-key colour vector.
    function automatic logic [NUM_KEYS-1:0] fkc_plane(input logic [2*NUM_KEYS-1:0] col,
                                                      input int                    sel);
        logic [NUM_KEYS-1:0] p;
        p = '0;
        for (int k = 0; k < NUM_KEYS; k++) begin
            p[k] = col[2*k+sel];
        end
        return p;
    endfunction

    // Lowest numbered pressed key wins when several arrive together.
    function automatic logic [IDX_W-1:0] fkc_first_set(input logic [NUM_KEYS-1:0] v);
        logic [IDX_W-1:0] idx;
        idx = '0;
        for (int k = NUM_KEYS - 1; k >= 0; k--) begin
            if (v[k]) begin
                idx = IDX_W'(k);
            end
        end
        return idx;
    endfunction
endpackage

// file: fkc_key_if.sv
// Link between the key press recogniser and the controller core.
// Assumes both ends run on core_clk.
`timescale 1ns/1ps
interface fkc_key_if;
    logic [fkc_pkg::NUM_KEYS-1:0] key_sync;
    logic                         qual;
    logic [fkc_pkg::IDX_W-1:0]    idx;
    logic                         held;
    logic                         busy;

    modport rec (input key_sync, output qual, idx, held, busy);
    modport ctl (output key_sync, input qual, idx, held, busy);
endinterface

// file: fkc_recogniser.sv
// Single-key press recogniser with a hold-time qualification filter.
// Assumes key_sync is already synchronised to core_clk.
`timescale 1ns/1ps
module fkc_recogniser #(
    parameter int QUAL_CYCLES = fkc_pkg::QUAL_CYC
) (
    // Clock and reset.
    input  wire logic core_clk,
    input  wire logic srst,
    // Key link.
    fkc_key_if.rec    kif
);
    import fkc_pkg::*;

    localparam int CNT_W = $clog2(QUAL_CYCLES + 1);

    typedef struct packed {
        fkc_rec_t         state;
        logic [IDX_W-1:0] idx;
        logic [CNT_W-1:0] cnt;
        logic             qual;
        logic             held;
    } fkc_rec_reg_t;

    fkc_rec_reg_t r;
    fkc_rec_reg_t next_r;

    always_comb begin
        next_r      = r;
        next_r.qual = 1'b0;
        case (r.state)
            FKC_IDLE: begin
                if (|kif.key_sync) begin
                    // Other keys are not looked at until this one is released.
                    next_r.idx   = fkc_first_set(kif.key_sync);
                    next_r.cnt   = '0;
                    next_r.state = FKC_QUAL;
                end
            end
            FKC_QUAL: begin
                if (!kif.key_sync[r.idx]) begin
                    // A break in the hold restarts qualification, so glitches die here.
                    next_r.state = FKC_IDLE;
                end else if (r.cnt == CNT_W'(QUAL_CYCLES - 1)) begin
                    next_r.qual  = 1'b1;
                    next_r.held  = 1'b1;
                    next_r.state = FKC_HELD;
                end else begin
                    next_r.cnt = CNT_W'(r.cnt + 1'b1);
                end
            end
            FKC_HELD: begin
                if (!kif.key_sync[r.idx]) begin
                    next_r.held  = 1'b0;
                    next_r.state = FKC_IDLE;
                end
            end
            default: begin
                next_r.held  = 1'b0;
                next_r.state = FKC_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            r       <= '0;
            r.state <= FKC_IDLE;
        end else begin
            r <= next_r;
        end
    end

    assign kif.qual = r.qual;
    assign kif.idx  = r.idx;
    assign kif.held = r.held;
    assign kif.busy = (r.state != FKC_IDLE);
endmodule

// file: fkc_top.sv
// Function key controller core: key command logic, indicators, backup store and APB registers.
// Assumes asynchronous key and backup store inputs and a battery-backed store outside.
`timescale 1ns/1ps
module fkc_top #(
    parameter int QUAL_CYCLES = fkc_pkg::QUAL_CYC
) (
    // Clock and reset.
    input  wire logic                          core_clk,
    input  wire logic                          srst,
    // APB slave.
    input  wire logic [fkc_pkg::ADDR_W-1:0]    paddr,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    // Front-panel keys, high while pressed.
    input  wire logic [fkc_pkg::NUM_KEYS-1:0]  key_pin,
    // Battery-backed store.
    input  wire logic                          bkp_valid,
    input  wire logic [fkc_pkg::NUM_KEYS-1:0]  bkp_rd_data,
    output logic                               bkp_wr_en,
    output logic      [fkc_pkg::NUM_KEYS-1:0]  bkp_wr_data,
    // Commands to the scheme logic.
    output logic      [fkc_pkg::NUM_KEYS-1:0]  key_cmd,
    // Three-colour indicators, both planes lit gives the third colour.
    output logic      [fkc_pkg::NUM_KEYS-1:0]  led_red,
    output logic      [fkc_pkg::NUM_KEYS-1:0]  led_green
);
    import fkc_pkg::*;

    typedef struct packed {
        logic [NUM_KEYS-1:0]   key_s1;
        logic [NUM_KEYS-1:0]   key_s2;
        logic                  bv_s1;
        logic                  bv_s2;
        logic [NUM_KEYS-1:0]   bd_s1;
        logic [NUM_KEYS-1:0]   bd_s2;
        fkc_boot_t             boot;
        logic [1:0]            boot_cnt;
        logic                  bkp_seen;
        logic [NUM_KEYS-1:0]   key_state;
        logic [NUM_KEYS-1:0]   behaviour;
        logic [NUM_KEYS-1:0]   enable;
        logic [NUM_KEYS-1:0]   lock;
        logic [2*NUM_KEYS-1:0] led_on;
        logic [2*NUM_KEYS-1:0] led_off;
        logic [NUM_KEYS-1:0]   key_cmd;
        logic [NUM_KEYS-1:0]   led_red;
        logic [NUM_KEYS-1:0]   led_green;
        logic                  bkp_wr_en;
        logic [NUM_KEYS-1:0]   bkp_wr_data;
        logic [31:0]           prdata;
        logic                  pready;
        logic                  pslverr;
    } fkc_top_reg_t;

    fkc_top_reg_t r;
    fkc_top_reg_t next_r;

    fkc_key_if kif ();

    fkc_recogniser #(
        .QUAL_CYCLES (QUAL_CYCLES)
    ) u_recogniser (
        .core_clk (core_clk),
        .srst     (srst),
        .kif      (kif)
    );

    assign kif.key_sync = r.key_s2;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    logic [2*NUM_KEYS-1:0] colour;
    logic                  acc_first;
    logic                  acc_done;

    always_comb begin
        next_r    = r;
        colour    = '0;
        acc_first = psel && penable && !r.pready;
        acc_done  = psel && penable && r.pready;

        // Two-stage synchronisers for the key and backup store inputs; the APB inputs are used directly.
        next_r.key_s1 = key_pin;
        next_r.key_s2 = r.key_s1;
        next_r.bv_s1  = bkp_valid;
        next_r.bv_s2  = r.bv_s1;
        next_r.bd_s1  = bkp_rd_data;
        next_r.bd_s2  = r.bd_s1;

        next_r.bkp_wr_en = 1'b0;

        case (r.boot)
            FKC_BOOT_WAIT: begin
                // Give the synchronisers time to carry the store contents across.
                if (r.boot_cnt == 2'(RESTORE_WAIT - 1)) begin
                    next_r.boot = FKC_BOOT_LOAD;
                end else begin
                    next_r.boot_cnt = 2'(r.boot_cnt + 1'b1);
                end
            end
            FKC_BOOT_LOAD: begin
                next_r.bkp_seen = r.bv_s2;
                if (r.bv_s2) begin
                    next_r.key_state = r.bd_s2;
                end else begin
                    next_r.key_state = '0;
                end
                next_r.bkp_wr_data = next_r.key_state;
                next_r.boot        = FKC_RUN;
            end
            FKC_RUN: begin
                for (int k = 0; k < NUM_KEYS; k++) begin
                    if (r.behaviour[k]) begin
                        // Only the one-cycle qualification pulse flips the state.
                        if (kif.qual && kif.idx == IDX_W'(k) && r.enable[k] && !r.lock[k]) begin
                            next_r.key_state[k] = !r.key_state[k];
                        end
                    end else begin
                        // Follows the held key directly; a lock pins it low.
                        next_r.key_state[k] = kif.held && kif.idx == IDX_W'(k)
                                              && r.enable[k] && !r.lock[k];
                    end
                end
                // Every change is written through so the store always holds the latest state.
                if (r.key_state != r.bkp_wr_data) begin
                    next_r.bkp_wr_en   = 1'b1;
                    next_r.bkp_wr_data = r.key_state;
                end
            end
            default: begin
                next_r.boot     = FKC_BOOT_WAIT;
                next_r.boot_cnt = '0;
            end
        endcase

        // A disabled key never reaches the scheme logic, whatever its stored state.
        next_r.key_cmd = r.key_state & r.enable;

        for (int k = 0; k < NUM_KEYS; k++) begin
            if (r.key_cmd[k]) begin
                colour[2*k +: 2] = r.led_on[2*k +: 2];
            end else begin
                colour[2*k +: 2] = r.led_off[2*k +: 2];
            end
        end
        next_r.led_red   = fkc_plane(colour, COL_RED_BIT);
        next_r.led_green = fkc_plane(colour, COL_GREEN_BIT);

        ////////////////////////////////////////////////////////////////////////////////////////
        // APB: one wait state, data and pready are prepared in the first access cycle.

        next_r.pready  = acc_first;
        next_r.pslverr = 1'b0;
        if (acc_first) begin
            next_r.prdata = '0;
            case (paddr)
                ADDR_KEY_STATE: next_r.prdata[NUM_KEYS-1:0] = r.key_cmd;
                ADDR_BEHAVIOUR: next_r.prdata[NUM_KEYS-1:0] = r.behaviour;
                ADDR_ENABLE:    next_r.prdata[NUM_KEYS-1:0] = r.enable;
                ADDR_LOCK:      next_r.prdata[NUM_KEYS-1:0] = r.lock;
                ADDR_LED_ON:    next_r.prdata[2*NUM_KEYS-1:0] = r.led_on;
                ADDR_LED_OFF:   next_r.prdata[2*NUM_KEYS-1:0] = r.led_off;
                ADDR_STATUS: begin
                    next_r.prdata[STAT_BUSY_BIT]                 = kif.busy;
                    next_r.prdata[STAT_HELD_BIT]                 = kif.held;
                    next_r.prdata[STAT_IDX_LSB +: IDX_W]         = kif.idx;
                    next_r.prdata[STAT_BKP_BIT]                  = r.bkp_seen;
                    next_r.prdata[STAT_RUN_BIT]                  = (r.boot == FKC_RUN);
                end
                default: next_r.pslverr = 1'b1;
            endcase
        end

        // Writes land on the edge that completes the transfer.
        if (acc_done && pwrite) begin
            case (paddr)
                ADDR_BEHAVIOUR: next_r.behaviour = pwdata[NUM_KEYS-1:0];
                ADDR_ENABLE:    next_r.enable    = pwdata[NUM_KEYS-1:0];
                ADDR_LOCK:      next_r.lock      = pwdata[NUM_KEYS-1:0];
                ADDR_LED_ON:    next_r.led_on    = pwdata[2*NUM_KEYS-1:0];
                ADDR_LED_OFF:   next_r.led_off   = pwdata[2*NUM_KEYS-1:0];
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // State register.

    always_ff @(posedge core_clk) begin
        if (srst) begin
            r           <= '0;
            r.boot      <= FKC_BOOT_WAIT;
            r.behaviour <= RST_BEHAVIOUR;
            r.enable    <= RST_ENABLE;
            r.lock      <= RST_LOCK;
            r.led_on    <= RST_LED_ON;
            r.led_off   <= RST_LED_OFF;
        end else begin
            r <= next_r;
        end
    end

    assign prdata      = r.prdata;
    assign pready      = r.pready;
    assign pslverr     = r.pslverr;
    assign bkp_wr_en   = r.bkp_wr_en;
    assign bkp_wr_data = r.bkp_wr_data;
    assign key_cmd     = r.key_cmd;
    assign led_red     = r.led_red;
    assign led_green   = r.led_green;
endmodule

// file: fkc_key_panel.sv
// Operator key panel model that presses keys on request.
// Assumes requests change just after a rising core_clk edge.
`timescale 1ns/1ps
module fkc_key_panel (
    // Clock.
    input  wire logic                         core_clk,
    // Requests from the bench.
    input  wire logic [fkc_pkg::NUM_KEYS-1:0] press,
    input  wire logic                         chatter,
    // Key contacts, high while pressed.
    output logic      [fkc_pkg::NUM_KEYS-1:0] key_pin
);
    import fkc_pkg::*;
    logic flick = 1'b0;
    // Bouncing contacts open every other cycle, so a chattering key never holds steady.
    always @(posedge core_clk) begin
        flick   <= ~flick;
        key_pin <= chatter ? (press & {NUM_KEYS{flick}}) : press;
    end
endmodule

// file: fkc_top_sva.sv
// Checker of the function key controller's port behaviour.
// Assumes it is bound to fkc_top and that key_pin is the raw contact level.
`timescale 1ns/1ps
module fkc_top_sva #(
    parameter int QUAL_CYCLES = fkc_pkg::QUAL_CYC
) (
    // Clock and reset.
    input wire logic                         core_clk,
    input wire logic                         srst,
    // APB.
    input wire logic                         psel,
    input wire logic                         penable,
    input wire logic [31:0]                  prdata,
    input wire logic                         pready,
    input wire logic                         pslverr,
    // Keys, store and commands.
    input wire logic [fkc_pkg::NUM_KEYS-1:0] key_pin,
    input wire logic                         bkp_wr_en,
    input wire logic [fkc_pkg::NUM_KEYS-1:0] bkp_wr_data,
    input wire logic [fkc_pkg::NUM_KEYS-1:0] key_cmd,
    input wire logic [fkc_pkg::NUM_KEYS-1:0] led_red,
    input wire logic [fkc_pkg::NUM_KEYS-1:0] led_green
);
    import fkc_pkg::*;
    int unsigned run_cnt;
    int unsigned hold_cnt;
    int unsigned idle_cnt;
    // The restore phase changes many keys at once, so key checks wait until it is over.
    always_ff @(posedge core_clk) run_cnt <= srst ? 0 : (run_cnt < 31 ? run_cnt + 1 : run_cnt);
    always_ff @(posedge core_clk) hold_cnt <= (srst || key_pin == '0) ? 0 : hold_cnt + 1;
    always_ff @(posedge core_clk) idle_cnt <= (srst || key_pin != '0) ? 0 : idle_cnt + 1;
    ////////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    sequence s_access;
        psel && penable && !pready;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    AST_APB_ANSWER: assert property (s_access |=> s_answer)
        else $error("APB answer is not one pulse after one wait state");
    AST_READY_CAUSE: assert property (pready |-> $past(psel && penable))
        else $error("pready without an access");
    AST_SLVERR_READY: assert property (pslverr |-> pready && prdata == '0)
        else $error("pslverr without pready or with read data");
    AST_RESET_ZERO: assert property (@(posedge core_clk) disable iff (1'b0)
        srst |=> key_cmd == '0 && led_red == '0 && led_green == '0 && !pready && !bkp_wr_en)
        else $error("outputs not cleared by reset");
    AST_BKP_PULSE: assert property (bkp_wr_en |=> !bkp_wr_en)
        else $error("store write longer than one cycle");
    AST_ONE_KEY: assert property (
        run_cnt >= 20 |-> $onehot0(bkp_wr_data ^ $past(bkp_wr_data)))
        else $error("more than one key changed at once");
    AST_NO_KEY_STABLE: assert property (run_cnt >= 20 && idle_cnt >= 12 |->
        !bkp_wr_en && $stable(bkp_wr_data))
        else $error("key state changed with no key pressed");
    AST_QUAL_HOLD: assert property (
        run_cnt >= 20 && |(bkp_wr_data & ~$past(bkp_wr_data)) |-> hold_cnt >= QUAL_CYCLES)
        else $error("key state set without a qualified hold");
endmodule
bind fkc_top fkc_top_sva #(.QUAL_CYCLES(QUAL_CYCLES)) fkc_top_sva_inst (
    .core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .key_pin(key_pin), .bkp_wr_en(bkp_wr_en),
    .bkp_wr_data(bkp_wr_data), .key_cmd(key_cmd), .led_red(led_red), .led_green(led_green));

// file: fkc_top_tb.sv
// Self-checking bench of the function key controller.
// Assumes the short qualification parameter and the key panel model.
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end
module fkc_top_tb;
    import fkc_pkg::*;
    localparam int QC = 8;
    logic core_clk, srst, psel, penable, pwrite, pready, pslverr, chatter, err, bkp_valid;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [NUM_KEYS-1:0] key_pin, bkp_rd_data, bkp_wr_data, key_cmd, led_red, led_green, press;
    logic bkp_wr_en;
    int error_cnt = 0, checked = 0, wr_pulses = 0, p0;
    fkc_top #(.QUAL_CYCLES(QC)) fkc_top_inst (.core_clk(core_clk), .srst(srst), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .key_pin(key_pin), .bkp_valid(bkp_valid),
        .bkp_rd_data(bkp_rd_data), .bkp_wr_en(bkp_wr_en), .bkp_wr_data(bkp_wr_data),
        .key_cmd(key_cmd), .led_red(led_red), .led_green(led_green));
    fkc_key_panel fkc_key_panel_inst (.core_clk(core_clk), .press(press), .chatter(chatter),
        .key_pin(key_pin));
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk) if (bkp_wr_en === 1'b1) wr_pulses++;
    // Scheme-side stretcher: a command keeps its effect for 16 cycles after it falls.
    logic [4:0] stretch_cnt;
    always @(posedge core_clk) begin
        if (srst) stretch_cnt <= 5'h00;
        else if (key_cmd != '0) stretch_cnt <= 5'h10;
        else if (stretch_cnt != 5'h00) stretch_cnt <= stretch_cnt - 5'h01;
    end
    ////////////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Read data and the error flag are taken at the rising edge that finds pready high.
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) begin
            if (n == 20) begin
                error_cnt++;
                test_done();
            end
            n++;
            @(posedge core_clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask
    task automatic wait_cmd(input int k, input logic v);
        int n = 0;
        while (key_cmd[k] !== v && n < QC + 40) begin
            @(negedge core_clk);
            n++;
        end
        if (n == QC + 40) begin
            error_cnt++;
            test_done();
        end
    endtask
    task automatic hold(input logic [NUM_KEYS-1:0] m, input int n);
        @(posedge core_clk) press <= m;
        repeat (n) @(negedge core_clk);
    endtask
    task automatic rel();
        @(posedge core_clk) press <= '0;
        repeat (12) @(negedge core_clk);
    endtask
    task automatic do_reset(input logic v, input logic [NUM_KEYS-1:0] d);
        @(posedge core_clk);
        bkp_valid <= v;
        bkp_rd_data <= d;
        srst <= 1'b1;
        repeat (12) @(posedge core_clk);
        srst <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////////
    task automatic t_restore();
        do_reset(1'b1, 10'h2a5);
        wait_cmd(0, 1'b1);
        `CHK(key_cmd, 10'h2a5)
        repeat (30) @(negedge core_clk);
        rd_chk(ADDR_STATUS, 32'h300);
        do_reset(1'b0, 10'h3ff);
        // Watch every cycle: a wrong load would show only briefly before momentary keys drop it.
        repeat (30) begin
            @(negedge core_clk);
            `CHK(key_cmd, 10'h000)
            `CHK(bkp_wr_data, 10'h000)
        end
        rd_chk(ADDR_STATUS, 32'h200);
    endtask
    task automatic t_regs();
        rd_chk(ADDR_BEHAVIOUR, 32'h0);
        rd_chk(ADDR_ENABLE, 32'h3ff);
        rd_chk(ADDR_LOCK, 32'h0);
        rd_chk(ADDR_LED_ON, 32'haaaaa);
        rd_chk(ADDR_LED_OFF, 32'h0);
        apb(1'b1, ADDR_LED_OFF, 32'h55555);
        rd_chk(ADDR_LED_OFF, 32'h55555);
        `CHK(led_red, 10'h3ff)
        `CHK(led_green, 10'h000)
        apb(1'b1, ADDR_KEY_STATE, 32'h3ff);
        rd_chk(ADDR_KEY_STATE, 32'h0);
        rd_chk(8'h40, 32'h0);
        `CHK(err, 1'b1)
    endtask
    task automatic t_momentary();
        hold(10'h004, 0);
        wait_cmd(2, 1'b1);
        `CHK(key_cmd, 10'h004)
        repeat (2) @(negedge core_clk);
        `CHK(led_green, 10'h004)
        `CHK(led_red, 10'h3fb)
        rd_chk(ADDR_KEY_STATE, 32'h4);
        rd_chk(ADDR_STATUS, 32'h223);
        hold(10'h006, QC + 10);
        `CHK(key_cmd, 10'h004)
        @(posedge core_clk) press <= '0;
        wait_cmd(2, 1'b0);
        `CHK(key_cmd, 10'h000)
        `CHK(stretch_cnt != 5'h00, 1'b1)
        repeat (12) @(negedge core_clk);
    endtask
    task automatic t_glitch();
        hold(10'h008, QC - 4);
        rel();
        `CHK(key_cmd, 10'h000)
        chatter <= 1'b1;
        hold(10'h008, 4 * QC);
        `CHK(key_cmd, 10'h000)
        rel();
        chatter <= 1'b0;
    endtask
    task automatic t_toggle();
        apb(1'b1, ADDR_BEHAVIOUR, 32'h3ff);
        for (int k = 0; k < NUM_KEYS; k++) begin
            hold(10'h001 << k, 0);
            wait_cmd(k, 1'b1);
            `CHK(key_cmd, 10'h001 << k)
            rel();
            hold(10'h001 << k, 0);
            wait_cmd(k, 1'b0);
            rel();
        end
        p0 = wr_pulses;
        hold(10'h010, 4 * QC);
        `CHK(key_cmd, 10'h010)
        `CHK(wr_pulses - p0, 1)
        rel();
        `CHK(key_cmd, 10'h010)
        `CHK(bkp_wr_data, 10'h010)
    endtask
    task automatic t_enable_lock();
        apb(1'b1, ADDR_ENABLE, 32'h3ef);
        repeat (4) @(negedge core_clk);
        `CHK(key_cmd, 10'h000)
        `CHK(bkp_wr_data, 10'h010)
        hold(10'h010, QC + 10);
        rel();
        apb(1'b1, ADDR_ENABLE, 32'h3ff);
        repeat (4) @(negedge core_clk);
        `CHK(key_cmd, 10'h010)
        apb(1'b1, ADDR_LOCK, 32'h010);
        hold(10'h010, QC + 10);
        `CHK(key_cmd, 10'h010)
        rel();
        apb(1'b1, ADDR_BEHAVIOUR, 32'h3df);
        apb(1'b1, ADDR_LOCK, 32'h030);
        hold(10'h020, QC + 10);
        `CHK(key_cmd, 10'h010)
        rel();
        apb(1'b1, ADDR_LOCK, 32'h0);
        hold(10'h010, 0);
        wait_cmd(4, 1'b0);
        `CHK(key_cmd, 10'h000)
        rel();
    endtask
    initial begin
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        press = '0;
        chatter = 1'b0;
        bkp_valid = 1'b0;
        bkp_rd_data = '0;
        t_restore();
        t_regs();
        t_momentary();
        t_glitch();
        t_toggle();
        t_enable_lock();
        test_done();
    end
endmodule
